// file: design/instr_exec_pkg.sv
// Package for the move and rotate execution unit: opcodes, widths, reset values.
// Assumes a 14-bit instruction word presented once per instruction cycle.
package instr_exec_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned INSTR_W    = 14;
  localparam int unsigned FILE_DEPTH = 128;
  // Field positions inside the instruction word.
  localparam int unsigned TARGET_BIT = 7;
  localparam int unsigned INDEX_LSB  = 0;
  // Opcode patterns for the supported instructions.
  localparam logic [5:0] OPC_COPY_REG    = 6'h08;
  localparam logic [5:0] OPC_ROTATE_LEFT = 6'h0d;
  localparam logic [6:0] OPC_STORE_ACC   = 7'h01;
  localparam logic [3:0] OPC_LOAD_LIT    = 4'hc;
  localparam logic [13:0] OPC_IDLE       = 14'h0000;
  // Reset values.
  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic       FLAG_RESET  = 1'b0;
  localparam logic [7:0] FILE_RESET  = 8'h00;
  localparam logic [10:0] PC_RESET   = 11'h000;

  typedef enum logic [4:0] {
    OP_IDLE   = 5'b00001,
    OP_COPY   = 5'b00010,
    OP_STORE  = 5'b00100,
    OP_LOAD   = 5'b01000,
    OP_ROTATE = 5'b10000
  } op_t;
endpackage

// file: design/decode_if.sv
// Interface carrying the decoded instruction from decoder to execution core.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface decode_if;
  import instr_exec_pkg::*;
  op_t        op;
  logic       legal;
  logic       target;
  logic [6:0] index;
  logic [7:0] literal;
  modport dec (output op, legal, target, index, literal);
  modport exe (input op, legal, target, index, literal);
endinterface

// file: design/instr_decoder.sv
// Combinational decoder for the move, store, load, idle and rotate instructions.
// Assumes the instruction word is stable for the whole instruction cycle.
`timescale 1ns/1ps
module instr_decoder
  import instr_exec_pkg::*;
(
  input wire logic [13:0] instr,
  decode_if.dec           dec
);
  // Opcode matching; unsupported words are flagged illegal and act as idle.
  always_comb begin
    dec.op      = OP_IDLE;
    dec.legal   = 1'b1;
    dec.target  = instr[TARGET_BIT];
    dec.index   = instr[INDEX_LSB +: ADDR_W];
    dec.literal = instr[DATA_W-1:0];
    if (instr[13:8] == OPC_COPY_REG) begin
      dec.op = OP_COPY;
    end else if (instr[13:8] == OPC_ROTATE_LEFT) begin
      dec.op = OP_ROTATE;
    end else if (instr[13:7] == OPC_STORE_ACC) begin
      dec.op = OP_STORE;
    end else if (instr[13:10] == OPC_LOAD_LIT) begin
      dec.op = OP_LOAD; // Low two opcode bits are don't-care.
    end else if (instr == OPC_IDLE) begin
      dec.op = OP_IDLE;
    end else begin
      dec.legal = 1'b0;
    end
  end
endmodule

// file: design/move_rotate_instr_exec.sv
// Execution unit for a subset of an 8-bit core: move, store, load, idle, rotate.
// Assumes one instruction per clock, supplied by the fetch logic with instrValid.
// Function
// - Copy register to accumulator or itself
// - Copy updates zero flag from value
// - Store accumulator to register, flags kept
// - Load literal into accumulator, flags kept
// - Rotate left through carry, carry only
// - Rotate result to accumulator or register
`timescale 1ns/1ps
module move_rotate_instr_exec
  import instr_exec_pkg::*;
#(
  parameter int unsigned DEPTH = FILE_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        instrValid,
  input  wire logic [13:0] instr,
  output logic [7:0]       accOut,
  output logic             zeroFlag,
  output logic             carryFlag,
  output logic [10:0]      pcOut,
  output logic             illegalOut
);
  decode_if dec ();

  // Decoding is purely combinational; unsupported words come back as idle with legal low.
  instr_decoder u_dec (
    .instr (instr),
    .dec   (dec)
  );

  // The register file and the architectural state. The file is read
  // combinationally, so a word written at one edge is seen by the next
  // instruction without any bypass path.
  logic [7:0]  fileMem [DEPTH];
  logic [7:0]  acc_reg,   acc_next;
  logic        zero_reg,  zero_next;
  logic        carry_reg, carry_next;
  logic [10:0] pc_reg,    pc_next;
  logic        ill_reg,   ill_next;
  logic        fileWe;
  logic [6:0]  fileIdx;
  logic [7:0]  fileWdata;
  logic [7:0]  srcVal;

  // Every instruction that names a register reads it here; store and load ignore it.
  assign srcVal = fileMem[dec.index];

  // Next-state computation for accumulator, flags, file and program counter.
  always_comb begin
    acc_next   = acc_reg;
    zero_next  = zero_reg;
    carry_next = carry_reg;
    pc_next    = pc_reg;
    ill_next   = ill_reg;
    fileWe     = 1'b0;
    fileIdx    = dec.index;
    fileWdata  = srcVal;
    if (instrValid) begin
      pc_next  = pc_reg + 11'h001;
      ill_next = ~dec.legal;
      unique case (dec.op)
        OP_COPY: begin
          if (dec.target) begin
            fileWe = 1'b1;
          end else begin
            acc_next = srcVal;
          end
          zero_next = (srcVal == 8'h00);
        end
        OP_STORE: begin
          fileWe    = 1'b1;
          fileWdata = acc_reg;
        end
        OP_LOAD: begin
          acc_next = dec.literal;
        end
        OP_ROTATE: begin
          fileWdata  = {srcVal[6:0], carry_reg};
          carry_next = srcVal[7];
          if (dec.target) begin
            fileWe = 1'b1;
          end else begin
            acc_next = {srcVal[6:0], carry_reg};
          end
        end
        OP_IDLE: begin
          // Nothing but the program counter and the illegal mark moves.
        end
      endcase
    end
  end

  // Core state registers; the file is cleared by reset so tests start known.
  // Clearing every entry costs a wide reset fan-out, traded for a known file.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_reg   <= ACC_RESET;
      zero_reg  <= FLAG_RESET;
      carry_reg <= FLAG_RESET;
      pc_reg    <= PC_RESET;
      ill_reg   <= FLAG_RESET;
      for (int i = 0; i < DEPTH; i++) begin
        fileMem[i] <= FILE_RESET;
      end
    end else begin
      acc_reg   <= acc_next;
      zero_reg  <= zero_next;
      carry_reg <= carry_next;
      pc_reg    <= pc_next;
      ill_reg   <= ill_next;
      if (fileWe) begin
        fileMem[fileIdx] <= fileWdata;
      end
    end
  end

  // Outputs come straight from the state flip-flops.
  // This keeps the decode path off the pins, at the cost of one cycle of latency.
  assign accOut     = acc_reg;
  assign zeroFlag   = zero_reg;
  assign carryFlag  = carry_reg;
  assign pcOut      = pc_reg;
  assign illegalOut = ill_reg;

  // Helper copies of operands for multi-cycle relations.
  // Left without reset on purpose: it only feeds assertions, which are off in reset.
  logic [7:0] pastSrc;
  always_ff @(posedge clk) begin
    pastSrc <= srcVal;
  end

  // Copy: the moved value lands in the chosen target and sets the zero flag.
  a_copy_to_acc: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_COPY && !dec.target |=> accOut == pastSrc)
    else $error("copy did not load accumulator");
  a_copy_to_file: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_COPY && dec.target
      |=> fileMem[$past(dec.index)] == pastSrc && $stable(accOut))
    else $error("copy to itself altered register or accumulator");
  a_copy_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_COPY |=> zeroFlag == (pastSrc == 8'h00))
    else $error("copy zero flag wrong");

  // Store: the register takes the accumulator; accumulator and flags stay put.
  a_store_keeps_flags: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_STORE |=> $stable(zeroFlag) && $stable(carryFlag)
      && $stable(accOut))
    else $error("store disturbed flags");
  a_store_writes_file: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_STORE |=> fileMem[$past(dec.index)] == $past(accOut))
    else $error("store did not write accumulator");

  // Load: the literal reaches the accumulator; flags and register file stay put.
  a_load_literal: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_LOAD |=> accOut == $past(instr[7:0])
      && $stable(zeroFlag) && $stable(carryFlag))
    else $error("literal load wrong");
  a_load_keeps_file: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_LOAD |-> !fileWe)
    else $error("literal load wrote a register");

  // Rotate: the carry takes bit 7 and the old carry fills bit 0.
  a_rotate_carry: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_ROTATE |=> carryFlag == pastSrc[7]
      && $stable(zeroFlag))
    else $error("rotate carry wrong");
  a_rotate_acc: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_ROTATE && !dec.target
      |=> accOut == {pastSrc[6:0], $past(carryFlag)})
    else $error("rotate accumulator result wrong");
  a_rotate_keeps_file: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_ROTATE && !dec.target |-> !fileWe)
    else $error("rotate into accumulator wrote a register");
  a_rotate_file: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_ROTATE && dec.target
      |=> fileMem[$past(dec.index)] == {pastSrc[6:0], $past(carryFlag)} && $stable(accOut))
    else $error("rotate file result wrong");

  // Idle and unsupported words: only the counter and the illegal mark move.
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_IDLE |-> !fileWe
      ##1 $stable(accOut) && $stable(zeroFlag) && $stable(carryFlag)
      && pcOut == $past(pcOut) + 11'h001)
    else $error("idle changed state");
  a_pc_advances: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid |=> pcOut == $past(pcOut) + 11'h001)
    else $error("program counter did not advance");
  a_pc_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !instrValid |=> $stable(pcOut) && $stable(accOut) && $stable(zeroFlag)
      && $stable(carryFlag))
    else $error("state moved without an instruction");
  a_illegal_mark: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid |=> illegalOut == !$past(dec.legal))
    else $error("illegal mark wrong");

  // Side effects outside the instructions that own them.
  a_file_write_target: assert property (@(posedge clk) disable iff (!rst_n)
    fileWe |-> instrValid && (dec.op == OP_STORE
      || (dec.target && (dec.op == OP_COPY || dec.op == OP_ROTATE))))
    else $error("register written by the wrong instruction");
  a_zero_only_copy: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op != OP_COPY |=> $stable(zeroFlag))
    else $error("zero flag moved outside copy");
  a_carry_only_rotate: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op != OP_ROTATE |=> $stable(carryFlag))
    else $error("carry moved outside rotate");

  // Scenarios worth seeing at least once in a run.
  c_copy_self: cover property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_COPY && dec.target && srcVal == 8'h00);
  c_rotate_back: cover property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_ROTATE && dec.target && srcVal[7]);
  c_store_then_copy: cover property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_STORE ##1 instrValid && dec.op == OP_COPY);
  c_load_literal: cover property (@(posedge clk) disable iff (!rst_n)
    instrValid && dec.op == OP_LOAD);
  c_illegal_word: cover property (@(posedge clk) disable iff (!rst_n)
    instrValid && !dec.legal);
endmodule

// file: tb/move_rotate_instr_exec_tb.sv
// Self-checking bench for the move and rotate execution unit.
// Assumes one cycle of latency and all state cleared by a synchronous reset.
`timescale 1ns/1ps
module move_rotate_instr_exec_tb;
  import instr_exec_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        instrValid;
  logic [13:0] instr;
  logic [7:0]  accOut;
  logic        zeroFlag;
  logic        carryFlag;
  logic        illegalOut;
  logic [10:0] pcOut;
  logic [7:0]  mem [128];
  logic [7:0]  acc;
  logic        z;
  logic        c;
  logic        ill;
  logic [10:0] pc;
  int          errors;
  int          checked;
  int          seed;

  move_rotate_instr_exec i_dut (
    .clk       (clk),
    .rst_n     (rst_n),
    .instrValid(instrValid),
    .instr     (instr),
    .accOut    (accOut),
    .zeroFlag  (zeroFlag),
    .carryFlag (carryFlag),
    .pcOut     (pcOut),
    .illegalOut(illegalOut)
  );

  // Free-running core clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reference model state after a reset.
  function automatic void model_reset();
    foreach (mem[i]) mem[i] = 8'h00;
    {acc, z, c, ill, pc} = '0;
  endfunction

  // Reference model of one executed word; unknown encodings only advance the counter and set the illegal mark.
  function automatic void apply(input logic [13:0] w);
    logic [7:0] v;
    v = mem[w[6:0]];
    ill = 1'b0;
    pc = pc + 11'h001;
    if (w[13:8] == OPC_COPY_REG) begin
      z = (v == 8'h00);
      if (w[7]) begin
        mem[w[6:0]] = v;
      end else begin
        acc = v;
      end
    end else if (w[13:8] == OPC_ROTATE_LEFT) begin
      if (w[7]) begin
        mem[w[6:0]] = {v[6:0], c};
      end else begin
        acc = {v[6:0], c};
      end
      c = v[7];
    end else if (w[13:7] == OPC_STORE_ACC) begin
      mem[w[6:0]] = acc;
    end else if (w[13:10] == OPC_LOAD_LIT) begin
      acc = w[7:0];
    end else if (w != OPC_IDLE) begin
      ill = 1'b1;
    end
  endfunction

  // Builds a word of the given kind; the literal form also sets its don't-care bits.
  function automatic logic [13:0] mk(input int k, input logic [6:0] f, input logic [7:0] lit);
    case (k)
      0: mk = {OPC_COPY_REG, lit[7], f};
      1: mk = {OPC_ROTATE_LEFT, lit[7], f};
      2: mk = {OPC_STORE_ACC, f};
      3: mk = {OPC_LOAD_LIT, f[1:0], lit};
      4: mk = OPC_IDLE;
      default: mk = 14'h0020;
    endcase
  endfunction

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Executes one word and compares every visible result one cycle later.
  task automatic run(input logic [13:0] w);
    instr = w;
    instrValid = 1'b1;
    @(posedge clk);
    #1;
    apply(w);
    check(11'(accOut), 11'(acc));
    check(11'(zeroFlag), 11'(z));
    check(11'(carryFlag), 11'(c));
    check(pcOut, pc);
    check(11'(illegalOut), 11'(ill));
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Corner cases first, then a mid-run reset, then seeded random words back to back.
  initial begin
    {rst_n, instrValid, instr, errors, checked} = '0;
    seed = 32'ha7e718ed;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    model_reset();
    run(mk(3, 7'h00, 8'h5a));
    run(mk(3, 7'h03, 8'he6));
    run(mk(2, 7'h7f, 8'h00));
    run(mk(1, 7'h7f, 8'h00));
    run(mk(1, 7'h7f, 8'h80));
    run(mk(0, 7'h7f, 8'h00));
    run(mk(0, 7'h00, 8'h80));
    run(mk(3, 7'h00, 8'hff));
    run(mk(4, 7'h00, 8'h00));
    run(mk(5, 7'h00, 8'h00));
    $display("test corner done");
    instrValid = 1'b0;
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    model_reset();
    run(mk(0, 7'h7f, 8'h00));
    instrValid = 1'b0;
    @(posedge clk);
    #1;
    check(pcOut, pc);
    check(11'(accOut), 11'(acc));
    $display("test reset done");
    repeat (600) run(mk($unsigned($random(seed)) % 6, 7'($random(seed)), 8'($random(seed))));
    instrValid = 1'b0;
    $display("test random done");
    tally_and_finish();
  end

  // Cuts a hang short well after the planned run of some 620 cycles.
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end
endmodule
